// ### inc/bacr_pkg.sv
// package: offsets, field positions and reset values of the bus area config register
package bacr_pkg;
	localparam logic [3:0] BACR_CFG_OFFSET = 4'h0;
	localparam logic [3:0] BACR_STATUS_OFFSET = 4'h4;
	localparam logic [31:0] BACR_CFG_RESET = 32'h00000000;
	localparam int BACR_BIT_BYTE_ORDER = 31;
	localparam int BACR_BIT_ROLE = 30;
	localparam int BACR_BIT_AREA0_MUXED = 29;
	localparam int BACR_BIT_IN_PULLUP_OFF = 25;
	localparam int BACR_BIT_OUT_PULLUP_OFF = 24;
	localparam int BACR_BIT_AREA1_BYTECTL = 21;
	localparam int BACR_BIT_AREA4_BYTECTL = 20;
	localparam int BACR_BIT_EXT_REQ = 19;
	localparam int BACR_BIT_PSHARE = 18;
	localparam int BACR_BIT_MUX16 = 17;
	localparam int BACR_BIT_FLOAT_CTL = 15;
	localparam int BACR_BIT_BURST_LSB = 11;
	// software-writable bits: 25,24,21..17,15..2,0
	localparam logic [31:0] BACR_WRITE_MASK = 32'h033EFFFD;
	localparam logic [2:0] BACR_BURST_MAX = 3'h4;
endpackage

// ### design/bacr_pin_sync.sv
// two-flop synchroniser for a group of slow mode pins
`timescale 1ns/100ps
`default_nettype none
module bacr_pin_sync #(
	parameter int WIDTH = 3
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	initial
	begin
		if (WIDTH < 1)
			$error("bacr_pin_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule
`default_nettype wire

// ### design/bacr_regs.sv
// bus area configuration register with avalon-mm slave and decoded controls
// Notes on behaviour
// - 32-bit register, zero on power-on reset except sampled pins; manual reset keeps it.
// - bit 31 samples byte-order pin at power-on reset, then read-only.
// - bit 30 samples role pin at power-on reset; 0 master, 1 slave.
// - bit 29 samples area 0 type pin; 1 means area 0 multiplexed.
// - reserved bits 28..26, 23, 22, 16, 1 read zero; write zero.
// - bit 25 high turns control input pad pull-ups off.
// - bit 24 high turns floating output pad pull-ups off.
// - bit 21 area 1 SRAM byte control; multiplexed bus overrides it.
// - bit 20 area 4 SRAM byte control; multiplexed bus overrides it.
// - bit 19 accepts external bus requests; ignored after slave startup.
// - bit 18 selects partial sharing, effective only after master startup.
// - bit 17 selects multiplexed bus for areas 1 to 6; cleared at reset.
// - bit 17 zero gives basic or burst ROM interface, one multiplexed.
// - bit 15 zero floats address pins in standby and release; one drives.
// - bits 13..11 area 0 burst length code; ignored when area 0 multiplexed.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module bacr_regs
	import bacr_pkg::*;
#(
	parameter int STRAP_DELAY = 2
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic manual_rst_i,
	input wire logic byte_order_mode_pin_i,
	input wire logic role_mode_pin_i,
	input wire logic area0_type_mode_pin_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	output logic little_endian_o,
	output logic slave_role_o,
	output logic area0_muxed_type_o,
	output logic input_pullup_off_o,
	output logic output_pullup_off_o,
	output logic area1_sram_bytectl_o,
	output logic area4_sram_bytectl_o,
	output logic ext_request_accept_o,
	output logic partial_sharing_sel_o,
	output logic areas1to6_muxed_bus_o,
	output logic addr_pins_float_ctl_o,
	output logic area0_burst_en_o,
	output logic [2:0] area0_burst_len_o,
	output logic straps_valid_o
);
	typedef enum logic [1:0] {
		BACR_IDLE = 2'b00,
		BACR_ACK = 2'b01
	} bacr_state_t;

	logic [31:0] cfg_ff;
	logic [31:0] nxt_cfg;
	logic [2:0] strap_ff;
	logic strap_done_ff;
	logic [3:0] strap_cnt_ff;
	logic [2:0] pins_sync;
	bacr_state_t state_ff;
	bacr_state_t nxt_state;
	logic [31:0] rdata_ff;
	logic [1:0] resp_ff;
	logic wait_ff;
	logic [31:0] out_ff;
	logic [2:0] burst_ff;
	logic burst_en_ff;
	logic done_ff;

	initial
	begin
		// below 2 the capture would see the synchroniser's reset value
		if (STRAP_DELAY < 2 || STRAP_DELAY > 15)
			$error("bacr_regs: STRAP_DELAY must be 2..15");
	end

	bacr_pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i({byte_order_mode_pin_i, role_mode_pin_i, area0_type_mode_pin_i}),
		.sync_o(pins_sync)
	);

	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// address decode and strobes
	wire sel_cfg = (avs_address_i == BACR_CFG_OFFSET);
	wire sel_status = (avs_address_i == BACR_STATUS_OFFSET);
	wire req = (avs_read_i || avs_write_i) && (state_ff == BACR_IDLE);
	// write lands on the edge at which waitrequest is seen low
	wire wr_cfg = (state_ff == BACR_ACK) && avs_write_i && sel_cfg;
	wire [31:0] wmask = lane_mask(avs_byteenable_i) & BACR_WRITE_MASK;
	// sampled pins packed over stored fields
	wire [31:0] cfg_view = {strap_ff, cfg_ff[28:0]};
	wire [31:0] status_view = {31'h00000000, strap_done_ff};
	wire [31:0] rd_mux = sel_cfg ? cfg_view : (sel_status ? status_view : 32'h00000000);
	wire bad_addr = !(sel_cfg || sel_status);

	assign nxt_cfg = (cfg_ff & ~(wr_cfg ? wmask : 32'h00000000))
		| (avs_writedata_i & (wr_cfg ? wmask : 32'h00000000));

	always_comb
	begin
		unique case (state_ff)
			BACR_IDLE: nxt_state = req ? BACR_ACK : BACR_IDLE;
			BACR_ACK: nxt_state = BACR_IDLE;
			default: nxt_state = BACR_IDLE;
		endcase
	end

	// only power-on reset clears; manual reset does not touch the register
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			cfg_ff <= BACR_CFG_RESET;
		else
			cfg_ff <= nxt_cfg;
	end

	// pins captured after reset release, then frozen
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			strap_ff <= 3'h0;
			strap_done_ff <= 1'b0;
			strap_cnt_ff <= 4'h0;
		end
		else if (!strap_done_ff)
		begin
			strap_cnt_ff <= strap_cnt_ff + 4'h1;
			if (strap_cnt_ff == 4'(STRAP_DELAY))
			begin
				strap_ff <= pins_sync;
				strap_done_ff <= 1'b1;
			end
		end
	end

	// bus answer: one wait cycle, then data and waitrequest low together
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_ff <= BACR_IDLE;
			rdata_ff <= 32'h00000000;
			resp_ff <= 2'h0;
			wait_ff <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
			wait_ff <= !req;
			if (req)
			begin
				rdata_ff <= avs_read_i ? rd_mux : 32'h00000000;
				resp_ff <= bad_addr ? 2'h3 : 2'h0;
			end
		end
	end

	// pull-up controls straight from stored bits
	// multiplexed selection for areas 1 to 6
	wire mux16 = cfg_ff[BACR_BIT_MUX16];
	// multiplexed bus wins over byte control
	wire a1_bc = cfg_ff[BACR_BIT_AREA1_BYTECTL] && !mux16;
	// multiplexed bus wins over byte control
	wire a4_bc = cfg_ff[BACR_BIT_AREA4_BYTECTL] && !mux16;
	wire ext_req = cfg_ff[BACR_BIT_EXT_REQ] && !strap_ff[1];
	wire pshare = cfg_ff[BACR_BIT_PSHARE] && !strap_ff[1];
	// burst code, reserved codes and muxed area 0 give normal access
	wire [2:0] burst_code = cfg_ff[BACR_BIT_BURST_LSB +: 3];
	wire burst_ok = (burst_code != 3'h0) && (burst_code <= BACR_BURST_MAX) && !strap_ff[0];

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			out_ff <= 32'h00000000;
			burst_ff <= 3'h0;
			burst_en_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			out_ff <= {strap_ff, 3'h0, cfg_ff[BACR_BIT_IN_PULLUP_OFF],
				cfg_ff[BACR_BIT_OUT_PULLUP_OFF], 2'h0, a1_bc, a4_bc, ext_req,
				pshare, mux16, 1'b0, cfg_ff[BACR_BIT_FLOAT_CTL], 15'h0000};
			burst_ff <= burst_ok ? burst_code : 3'h0;
			burst_en_ff <= burst_ok;
			done_ff <= strap_done_ff;
		end
	end

	assign avs_readdata_o = rdata_ff;
	assign avs_waitrequest_o = wait_ff;
	assign avs_response_o = resp_ff;
	assign little_endian_o = out_ff[BACR_BIT_BYTE_ORDER];
	assign slave_role_o = out_ff[BACR_BIT_ROLE];
	assign area0_muxed_type_o = out_ff[BACR_BIT_AREA0_MUXED];
	assign input_pullup_off_o = out_ff[BACR_BIT_IN_PULLUP_OFF];
	assign output_pullup_off_o = out_ff[BACR_BIT_OUT_PULLUP_OFF];
	assign area1_sram_bytectl_o = out_ff[BACR_BIT_AREA1_BYTECTL];
	assign area4_sram_bytectl_o = out_ff[BACR_BIT_AREA4_BYTECTL];
	assign ext_request_accept_o = out_ff[BACR_BIT_EXT_REQ];
	assign partial_sharing_sel_o = out_ff[BACR_BIT_PSHARE];
	assign areas1to6_muxed_bus_o = out_ff[BACR_BIT_MUX16];
	assign addr_pins_float_ctl_o = out_ff[BACR_BIT_FLOAT_CTL];
	assign area0_burst_en_o = burst_en_ff;
	assign area0_burst_len_o = burst_ff;
	assign straps_valid_o = done_ff;

	// manual reset is accepted but deliberately unused
	wire unused_manual = manual_rst_i;
endmodule
`default_nettype wire

// ### testbench/bacr_props.sv
// port assertions for the bus area config register
`timescale 1ns/100ps
`default_nettype none
module bacr_regs_props (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic little_endian_o,
	input wire logic slave_role_o,
	input wire logic area0_muxed_type_o,
	input wire logic area1_sram_bytectl_o,
	input wire logic area4_sram_bytectl_o,
	input wire logic ext_request_accept_o,
	input wire logic partial_sharing_sel_o,
	input wire logic areas1to6_muxed_bus_o,
	input wire logic area0_burst_en_o,
	input wire logic [2:0] area0_burst_len_o,
	input wire logic straps_valid_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_ack;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bad answer timing");
	property p_rsv;
		avs_read_i && !avs_waitrequest_o |-> (avs_readdata_o & 32'h1CC10002) == 32'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit read high");
	property p_pin;
		$past(straps_valid_o, 2) |-> $stable({little_endian_o, slave_role_o, area0_muxed_type_o});
	endproperty
	a_pin: assert property (p_pin) else $error("sampled bit moved");
	property p_ext;
		ext_request_accept_o |-> !slave_role_o;
	endproperty
	a_ext: assert property (p_ext) else $error("request accept in slave");
	property p_psh;
		partial_sharing_sel_o |-> !slave_role_o;
	endproperty
	a_psh: assert property (p_psh) else $error("sharing in slave");
	property p_a1;
		area1_sram_bytectl_o |-> !areas1to6_muxed_bus_o;
	endproperty
	a_a1: assert property (p_a1) else $error("area1 byte ctl with mux");
	property p_a4;
		area4_sram_bytectl_o |-> !areas1to6_muxed_bus_o;
	endproperty
	a_a4: assert property (p_a4) else $error("area4 byte ctl with mux");
	property p_bst;
		area0_burst_en_o |-> !area0_muxed_type_o && area0_burst_len_o inside {[1:4]};
	endproperty
	a_bst: assert property (p_bst) else $error("bad area0 burst");
	cover property (avs_write_i && !avs_waitrequest_o);
	cover property (avs_read_i && !avs_waitrequest_o);
	cover property (area0_burst_en_o && area0_burst_len_o == 3'h4);
endmodule
bind bacr_regs bacr_regs_props u_props (.core_clk_i, .rst_i, .avs_read_i, .avs_write_i,
	.avs_readdata_o, .avs_waitrequest_o, .little_endian_o, .slave_role_o, .area0_muxed_type_o,
	.area1_sram_bytectl_o, .area4_sram_bytectl_o, .ext_request_accept_o, .partial_sharing_sel_o,
	.areas1to6_muxed_bus_o, .area0_burst_en_o, .area0_burst_len_o, .straps_valid_o);
`default_nettype wire

// ### testbench/tb_bus_area_control_register.sv
// self-checking bench for the bus area config register
`timescale 1ns/100ps
`default_nettype none
module tb_bus_area_control_register;
	logic clk = 0, rst = 1, man = 0, pe = 0, pr = 0, pa = 0, rd = 0, wr = 0;
	logic [3:0] adr = 4'h0, be = 4'hF;
	logic [31:0] wd = 32'h0, q, rdat;
	logic [1:0] r, resp;
	logic [2:0] pins, bl;
	logic wq, le, sr, a0, ip, op, a1, a4, ex, ps, mx, fl, ben, sv;
	int mismatches = 0, samples_checked = 0;
	always #5 clk = ~clk;
	bacr_regs u_dut (.core_clk_i(clk), .rst_i(rst), .manual_rst_i(man), .byte_order_mode_pin_i(pe),
		.role_mode_pin_i(pr), .area0_type_mode_pin_i(pa), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wq), .avs_response_o(resp), .little_endian_o(le), .slave_role_o(sr),
		.area0_muxed_type_o(a0), .input_pullup_off_o(ip), .output_pullup_off_o(op),
		.area1_sram_bytectl_o(a1), .area4_sram_bytectl_o(a4), .ext_request_accept_o(ex),
		.partial_sharing_sel_o(ps), .areas1to6_muxed_bus_o(mx), .addr_pins_float_ctl_o(fl),
		.area0_burst_en_o(ben), .area0_burst_len_o(bl), .straps_valid_o(sv));
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task report_and_stop;
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one word, held until the answer edge; settle time after it for decoded outputs
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		be <= b;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wq !== 1'b0 && n < 20);
		if (n >= 20)
			mismatches++;
		q = rdat;
		r = resp;
		rd <= 0;
		wr <= 0;
		repeat (3) @(posedge clk);
	endtask
	task do_reset(input logic [2:0] p);
		int n;
		@(posedge clk);
		pins = p;
		rst <= 1;
		{pe, pr, pa} <= p;
		repeat (16) @(posedge clk);
		rst <= 0;
		n = 0;
		while (sv !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
			mismatches++;
		repeat (3) @(posedge clk);
	endtask
	task t_pins;
		bus(0, 4'h0, 0, 4'hF);
		chk(q, {pins, 29'h0});
		chk(r, 2'b00);
		chk({le, sr, a0}, pins);
		chk({ip, op, a1, a4, ex, ps, mx, fl, ben, bl}, 12'h000);
		chk(sv, 1'b1);
		bus(0, 4'h4, 0, 4'hF);
		chk(q, 32'h00000001);
		chk(r, 2'b00);
	endtask
	task t_write;
		// reserved bits written as zero, read-only bits as one
		bus(1, 4'h0, 32'hE33EFFFD, 4'hF);
		bus(0, 4'h0, 0, 4'hF);
		chk(q, {pins, 29'h0} | 32'h033EFFFD);
		chk({mx, a1, a4, ip, op, fl, ben, bl}, 10'h270);
		chk({ex, ps}, {2{!pins[1]}});
		bus(1, 4'h0, 32'h0, 4'h4);
		bus(0, 4'h0, 0, 4'hF);
		chk(q, {pins, 29'h0} | 32'h0300FFFD);
	endtask
	task t_burst;
		for (int i = 0; i < 8; i++)
		begin
			bus(1, 4'h0, 32'h00300000 | (i << 11), 4'hF);
			chk(ben, i > 0 && i < 5 && !pins[0]);
			chk(bl, (i > 0 && i < 5 && !pins[0]) ? i : 0);
			chk({a1, a4}, 2'b11);
		end
	endtask
	task t_hold;
		{pe, pr, pa} <= ~pins;
		man <= 1;
		bus(0, 4'h8, 0, 4'hF);
		chk(r, 2'b11);
		chk(q, 32'h00000000);
		bus(1, 4'h8, 32'hFFFFFFFF, 4'hF);
		bus(1, 4'h4, 32'hFFFFFFFF, 4'hF);
		bus(0, 4'h0, 0, 4'hF);
		chk(q, {pins, 29'h0} | 32'h00303800);
		man <= 0;
	endtask
	initial
	begin
		#100000;
		mismatches++;
		report_and_stop;
	end
	initial
	begin
		do_reset(3'b101);
		t_pins;
		t_write;
		t_burst;
		t_hold;
		do_reset(3'b010);
		t_pins;
		t_write;
		t_burst;
		report_and_stop;
	end
endmodule
`default_nettype wire
